/* File: bench/aop_capture_model.sv */
// Downstream capture logic model for the converter output port
`timescale 1ns/1ps
`default_nettype none

module aop_capture_model
    import aop_pkg::*;
(
    // Clock
    input  wire logic         clk_i,
    // Converter pins
    input  wire logic         conv_clk_i,
    input  wire aop_word_type pin_data_i,
    input  wire aop_word_type pin_oe_i,
    // Captured word
    output var  logic         cap_valid_o,
    output var  aop_word_type cap_word_o
);
    aop_word_type last_r;
    aop_word_type bus_level;
    logic         conv_d_r;

    // Floating bits flip each cycle so no stale level passes
    always_comb begin
        for (int i = 0; i < $bits(aop_word_type); i++) begin
            bus_level[i] = pin_oe_i[i] ? pin_data_i[i] : ~last_r[i];
        end
    end

    always_ff @(posedge clk_i) begin
        last_r   <= bus_level;
        conv_d_r <= conv_clk_i;
    end

    always_ff @(posedge clk_i) begin
        cap_valid_o <= conv_clk_i && !conv_d_r;
        cap_word_o  <= bus_level;
    end
endmodule // aop_capture_model

`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench of the converter output port
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import aop_pkg::*;
    logic         clk_i, resetn_i, conv_clk_i, oe_n, pd, run, freeze, cap_valid;
    aop_word_type quant, data_o, oe_o, cap_word, frozen, last_exp, q_next;
    aop_word_type exp_q[$];
    aop_word_type tbl[3] = '{10'h200, 10'h1FF, 10'h000};
    logic [31:0]  seed = 32'hFCE0020B;
    int           errors = 0, cmp_count = 0, skip = 0, ph = 0, n_samp = 0, cycles = 0;

    aop_output_port dut (.clk_i(clk_i), .resetn_i(resetn_i), .conv_clk_i(conv_clk_i),
        .output_enable_n_i(oe_n), .power_down_input_i(pd), .quant_i(quant),
        .sample_code_bits_o(data_o), .sample_code_bits_oe_o(oe_o));
    aop_capture_model u_cap (.clk_i(clk_i), .conv_clk_i(conv_clk_i), .pin_data_i(data_o),
        .pin_oe_i(oe_o), .cap_valid_o(cap_valid), .cap_word_o(cap_word));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Conversion clock, 6 low and 6 high, and sample stream
    // ------------------------------------------------------------
    always @(negedge clk_i) begin
        if (!run) begin
            conv_clk_i <= 1'b0;
            ph = 0;
        end else if (ph == 5) begin
            ph = 0;
            conv_clk_i <= ~conv_clk_i;
            // New word set on rising edge, stable over the falling edge
            if (!conv_clk_i) begin
                seed = xorshift(seed);
                q_next = (n_samp < 3) ? tbl[n_samp] : seed[9:0];
                quant <= q_next;
                // Offset binary is the signed value lifted by half scale
                if (!pd) exp_q.push_back(q_next + 10'h200);
                n_samp++;
            end
        end else begin
            ph++;
        end
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        xorshift = v ^ (v << 5);
    endfunction

    task automatic check(input aop_word_type got, input aop_word_type exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Monitor: oldest expected word at each captured word
    // ------------------------------------------------------------
    always @(negedge clk_i) begin
        if (resetn_i && cap_valid) begin
            if (skip > 0) skip--;
            else if (freeze && !oe_n) check(cap_word, frozen);
            else if (!freeze) begin
                if (exp_q.size() == 0) begin
                    errors++;
                    $display("wrong value at %0t: word with no sample behind it", $time);
                end else begin
                    last_exp = exp_q.pop_front();
                    check(cap_word, last_exp);
                end
            end
            check(oe_o, oe_n ? 10'h000 : 10'h3FF);
        end
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("wrong value at %0t: run hangs", $time);
            print_verdict();
        end
    end

    task automatic do_reset();
        // Step off the capture cycle so the monitor never sees a cleared queue
        @(negedge clk_i);
        run <= 1'b0;
        resetn_i <= 1'b0;
        pd <= 1'b0;
        freeze = 1'b0;
        n_samp = 0;
        exp_q.delete();
        repeat (10) @(negedge clk_i);
        check(data_o, 10'h000);
        check(oe_o, 10'h000);
        resetn_i <= 1'b1;
        skip = 7;
        run <= 1'b1;
    endtask

    task automatic wait_caps(input int n);
        repeat (n) @(negedge clk_i iff cap_valid);
    endtask

    initial begin
        resetn_i = 1'b0;
        oe_n = 1'b0;
        pd = 1'b0;
        quant = '0;
        run = 1'b0;
        freeze = 1'b0;
        do_reset();
        wait_caps(30);
        // Power-down mid-stream: word on pins must hold
        @(negedge conv_clk_i);
        @(negedge clk_i);
        pd <= 1'b1;
        // Words still in the pipeline stay queued; they leave after wake
        frozen = exp_q.pop_front();
        freeze = 1'b1;
        wait_caps(3);
        @(posedge conv_clk_i);
        @(negedge clk_i);
        oe_n <= 1'b1;
        repeat (4) @(negedge clk_i);
        check(oe_o, 10'h000);
        wait_caps(2);
        @(posedge conv_clk_i);
        @(negedge clk_i);
        oe_n <= 1'b0;
        wait_caps(3);
        // Wake just after a falling edge: stalled words resume in order
        @(negedge conv_clk_i);
        @(negedge clk_i);
        pd <= 1'b0;
        wait_caps(1);
        @(negedge clk_i);
        freeze = 1'b0;
        wait_caps(10);
        // Second reset mid-run, then a fresh stream
        do_reset();
        wait_caps(25);
        print_verdict();
    end
endmodule // testbench

`default_nettype wire

/* File: rtl/aop_delay_mem.sv */
// Half-cycle pipeline store with registered read word
`timescale 1ns/1ps
`default_nettype none
`include "aop_defines.svh"

module aop_delay_mem
    import aop_pkg::*;
(
    // Clock and reset
    input  wire logic    clk_i,
    input  wire logic    resetn_i,
    // Control
    input  wire logic    shift_i,
    input  wire logic    load_i,
    input  wire aop_word_type data_i,
    // Read word
    output var  aop_word_type data_o
);

    // --------------------------------------------------------------
    // Stage registers
    // --------------------------------------------------------------
    aop_word_type stage_r [`AOP_HALF_STAGES];

    // First stage only takes new codes on a load, holds otherwise
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage_r[0] <= `AOP_WORD_RESET;
        end else if (shift_i && load_i) begin
            stage_r[0] <= data_i;
        end
    end

    genvar gi;
    generate
        for (gi = 1; gi < `AOP_HALF_STAGES; gi++) begin : g_stage
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    stage_r[gi] <= `AOP_WORD_RESET;
                end else if (shift_i) begin
                    stage_r[gi] <= stage_r[gi-1];
                end
            end
        end
    endgenerate

    assign data_o = stage_r[`AOP_HALF_STAGES-1];

endmodule // aop_delay_mem

`default_nettype wire

/* File: rtl/aop_output_port.sv */
// Output port of a 10-bit pipelined converter
// Operation
// - Ten-bit word, bit 0 least significant
// - Result appears 5.5 conversion cycles after sampling
// - Straight offset binary output coding
// - Enable high with power-down high floats outputs
// - Power-down with enable low freezes last word
// - Sample taken on conversion clock falling edge
// - Words valid at conversion clock rising edge
// - Enable low drives outputs, high disables
// - Power-down high halts, low converts
`timescale 1ns/1ps
`default_nettype none
`include "aop_defines.svh"

module aop_output_port
    import aop_pkg::*;
(
    // Clock and reset
    input  wire logic    clk_i,
    input  wire logic    resetn_i,
    // Converter pins
    input  wire logic    conv_clk_i,
    input  wire logic    output_enable_n_i,
    input  wire logic    power_down_input_i,
    // Quantizer result, two's complement, same clock domain
    input  wire aop_word_type quant_i,
    // Three-state data pins
    output var  aop_word_type sample_code_bits_o,
    output var  aop_word_type sample_code_bits_oe_o
);

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    logic [`AOP_SYNC_STAGES-1:0] conv_sync_r;
    logic [`AOP_SYNC_STAGES-1:0] oen_sync_r;
    logic [`AOP_SYNC_STAGES-1:0] pd_sync_r;
    logic                        conv_prev_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            conv_sync_r <= '0;
            oen_sync_r  <= '1;
            pd_sync_r   <= '0;
        end else begin
            conv_sync_r <= {conv_sync_r[0], conv_clk_i};
            oen_sync_r  <= {oen_sync_r[0], output_enable_n_i};
            pd_sync_r   <= {pd_sync_r[0], power_down_input_i};
        end
    end

    // Edge history only looks at the second flop
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            conv_prev_r <= 1'b0;
        end else begin
            conv_prev_r <= conv_sync_r[1];
        end
    end

    logic conv_s;
    logic oen_s;
    logic pd_s;
    logic rise_ev;
    logic fall_ev;

    assign conv_s  = conv_sync_r[1];
    assign oen_s   = oen_sync_r[1];
    assign pd_s    = pd_sync_r[1];
    assign rise_ev = conv_s && !conv_prev_r;
    assign fall_ev = !conv_s && conv_prev_r;

    // --------------------------------------------------------------
    // Mode
    // --------------------------------------------------------------
    aop_mode_type mode_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_r <= AOP_RUN;
        end else begin
            case (mode_r)
                AOP_RUN:  if (pd_s) mode_r <= AOP_HALT;
                AOP_HALT: if (!pd_s) mode_r <= AOP_RUN;
                default:  mode_r <= AOP_RUN;
            endcase
        end
    end

    logic running;
    assign running = (mode_r == AOP_RUN);

    // --------------------------------------------------------------
    // Coding and pipeline
    // --------------------------------------------------------------
    function automatic aop_word_type to_offset_bin(input aop_word_type v);
        to_offset_bin = {~v[`AOP_MSB], v[`AOP_MSB-1:0]};
    endfunction

    aop_word_type code_w;
    aop_word_type pipe_q;
    logic         shift_w;
    logic         load_w;

    assign code_w  = to_offset_bin(quant_i);
    // Every conversion edge in run mode advances one half-cycle stage
    assign shift_w = running && (rise_ev || fall_ev);
    assign load_w  = fall_ev;

    aop_delay_mem u_mem (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .shift_i  (shift_w),
        .load_i   (load_w),
        .data_i   (code_w),
        .data_o   (pipe_q)
    );

    // --------------------------------------------------------------
    // Output latch and drivers
    // --------------------------------------------------------------
    // Words only change on a rising edge; halted mode freezes the latch
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sample_code_bits_o <= `AOP_WORD_RESET;
        end else if (running && rise_ev) begin
            sample_code_bits_o <= pipe_q;
        end
    end

    // Enable alone decides drive, so power-down with enable high floats
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sample_code_bits_oe_o <= `AOP_OE_NONE;
        end else begin
            sample_code_bits_oe_o <= oen_s ? `AOP_OE_NONE : `AOP_OE_ALL;
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    sequence rise_run_s;
        running && rise_ev;
    endsequence

    sequence fall_run_s;
        running && fall_ev;
    endsequence

    property word_from_pipe_p;
        @(posedge clk_i) disable iff (!resetn_i)
        rise_run_s |=> (sample_code_bits_o == $past(pipe_q));
    endproperty

    property float_p;
        @(posedge clk_i) disable iff (!resetn_i)
        (oen_s && pd_s) |=> (sample_code_bits_oe_o == `AOP_OE_NONE);
    endproperty

    word_bits_a: assert property (word_from_pipe_p)
        else $error("output word not taken from pipeline end");

    pipe_latency_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (shift_w && !load_w) |=> (pipe_q == $past(u_mem.stage_r[`AOP_HALF_STAGES-2])))
        else $error("pipeline stage did not advance");

    zero_code_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (quant_i == `AOP_WORD_RESET) |-> (code_w == `AOP_CODE_ZERO))
        else $error("bipolar zero not coded as midscale");

    outputs_float_a: assert property (float_p)
        else $error("outputs driven with enable high in power-down");

    word_frozen_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (!running && !$past(running)) |-> $stable(sample_code_bits_o))
        else $error("word changed during power-down");

    sample_fall_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (fall_run_s ##1 1'b1) |-> (u_mem.stage_r[0] == $past(code_w)))
        else $error("sample not captured on falling edge");

    rise_update_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !$stable(sample_code_bits_o) |-> $past(rise_ev))
        else $error("word changed away from a rising edge");

    enable_drive_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !oen_s |=> (sample_code_bits_oe_o == `AOP_OE_ALL))
        else $error("outputs not driven with enable low");

    halt_mode_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        pd_s [*2] |-> (mode_r == AOP_HALT))
        else $error("power-down did not halt conversion");

    one_word_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        rise_run_s |=> !rise_ev [*2])
        else $error("more than one word per conversion cycle");

endmodule // aop_output_port

`default_nettype wire

/* File: shared/aop_defines.svh */
// Constants of the pipelined converter output port
`ifndef AOP_DEFINES_SVH
`define AOP_DEFINES_SVH

`define AOP_WORD_W        10
`define AOP_MSB           9
`define AOP_HALF_STAGES   11
`define AOP_SYNC_STAGES   2
`define AOP_CODE_ZERO     10'h200
`define AOP_CODE_POS_FS   10'h3FF
`define AOP_CODE_NEG_FS   10'h000
`define AOP_WORD_RESET    10'h000
`define AOP_OE_ALL        10'h3FF
`define AOP_OE_NONE       10'h000

`endif

/* File: shared/aop_pkg.sv */
// Types of the pipelined converter output port
`default_nettype none
`include "aop_defines.svh"

package aop_pkg;

    typedef logic [`AOP_WORD_W-1:0] aop_word_type;

    typedef enum logic [1:0] {
        AOP_RUN  = 2'b01,
        AOP_HALT = 2'b10
    } aop_mode_type;

endpackage : aop_pkg

`default_nettype wire
